// [hw/dtd_decode.v]
`include "dtd_map.vh"

// Functional notes
// - 8e plus mod byte: load segment register, 2 reg / 9 wide, 13 narrow.
// - 8c plus mod byte: store segment register, 2 reg / 11 wide, 15 narrow.
// - d7: table translate of accumulator low byte, 11 wide, 15 narrow.
// - 8d: write effective address into register, 6 clocks on both buses.
// - c5: far pointer into register and data segment, memory only, 18/26.
// - c4: far pointer into register and extra segment, memory only, 18/26.
// - 9f: flags copied into accumulator high byte, 2 clocks.
// - 9e: accumulator high byte copied into flags, 3 clocks.
// - Narrow bus: marked counts are byte; word memory transfer adds 4 clocks.
module dtd_decode (
  input  wire                    sys_clk,        // Processor clock
  input  wire                    rstn,           // Async reset, active low
  input  wire                    clk_en,         // Freezes all state while low
  input  wire                    op_valid,       // Instruction bytes present
  input  wire [7:0]              op_byte0,       // First opcode byte
  input  wire [7:0]              op_byte1,       // Mode/register/operand byte
  input  wire                    narrow_bus_pin, // Pin: high selects narrow bus
  output reg                     dec_valid,      // Decode result strobe, follows op_valid one enabled edge late
  output reg                     dec_known,      // Opcode belongs to this group
  output reg  [`DTD_CLS_W-1:0]   dec_class,      // One-hot form of instruction
  output reg  [`DTD_CNT_W-1:0]   dec_clocks,     // Minimum execution clocks
  output reg                     mem_operand,    // Operand is in memory
  output reg                     word_operand,   // Operand is 16 bits wide
  output reg                     illegal_form,   // Far load with register operand
  output reg  [2:0]              reg_field,      // Register select field
  output reg                     writes_acc_low, // accumulator_low_byte updated
  output reg                     writes_acc_high,// accumulator_high_byte updated
  output reg                     writes_flags,   // Flags updated
  output reg                     writes_seg,     // A segment register is loaded
  output reg                     narrow_bus      // Synchronised bus width
);

  // Bus width strap arrives from a pin; two stages before use.
  // A strap change reaches the count choice only two enabled edges later.
  reg nb_meta;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      nb_meta    <= 1'b0;
      narrow_bus <= 1'b0;
    end else if (clk_en) begin
      nb_meta    <= narrow_bus_pin;
      narrow_bus <= nb_meta;
    end
  end

  wire [1:0] mod_f  = op_byte1[`DTD_MOD_HI:`DTD_MOD_LO];
  wire       is_mem = (mod_f != `DTD_MOD_REG);
  wire       w_bit  = op_byte0[`DTD_WIDTH_BIT];
  wire       take   = clk_en && op_valid;

  // Move forms differ only in the width bit, so match the upper seven bits
  wire [6:0] opc_top        = op_byte0[`DTD_OPC_HI:`DTD_OPC_TOP_LO];
  wire       hit_mov_to_rm  = (opc_top == `DTD_OPC_MOV_TO_RM);
  wire       hit_mov_to_reg = (opc_top == `DTD_OPC_MOV_TO_REG);

  reg                  next_known;
  reg [`DTD_CLS_W-1:0] next_class;
  reg [`DTD_CNT_W-1:0] next_clocks;
  reg                  next_mem;
  reg                  next_word;
  reg                  next_illegal;
  reg                  next_acc_low;
  reg                  next_acc_high;
  reg                  next_flags;
  reg                  next_seg;
  reg [`DTD_CNT_W:0]   pen_sum;

  // Figures are minimums: queue starvation and wait states come on top
  always @* begin
    next_known    = 1'b1;
    next_class    = `DTD_CLS_NONE;
    next_clocks   = `DTD_CNT_NONE;
    next_mem      = 1'b0;
    next_word     = 1'b0;
    next_illegal  = 1'b0;
    next_acc_low  = 1'b0;
    next_acc_high = 1'b0;
    next_flags    = 1'b0;
    next_seg      = 1'b0;
    pen_sum       = {1'b0, `DTD_CNT_NONE};

    case (op_byte0)
      `DTD_OPC_SEG_LOAD: begin
        next_class[`DTD_CLS_SEG_LOAD] = 1'b1;
        next_mem  = is_mem;
        next_word = 1'b1;
        next_seg  = 1'b1;
        // Segment counts are already word figures, no penalty on top
        if (!is_mem)
          next_clocks = `DTD_CNT_REG_MOVE;
        else if (narrow_bus)
          next_clocks = `DTD_CNT_SEG_LOAD_NB;
        else
          next_clocks = `DTD_CNT_SEG_LOAD_WB;
      end
      `DTD_OPC_SEG_STORE: begin
        next_class[`DTD_CLS_SEG_STORE] = 1'b1;
        next_mem  = is_mem;
        next_word = 1'b1;
        if (!is_mem)
          next_clocks = `DTD_CNT_REG_MOVE;
        else if (narrow_bus)
          next_clocks = `DTD_CNT_SEG_STORE_NB;
        else
          next_clocks = `DTD_CNT_SEG_STORE_WB;
      end
      `DTD_OPC_TABLE_XLT: begin
        next_class[`DTD_CLS_TABLE_XLT] = 1'b1;
        next_mem     = 1'b1;
        next_acc_low = 1'b1;
        next_clocks  = narrow_bus ? `DTD_CNT_XLT_NB : `DTD_CNT_XLT_WB;
      end
      `DTD_OPC_EA_LOAD: begin
        // Address only, so no memory cycle is counted
        next_class[`DTD_CLS_EA_LOAD] = 1'b1;
        next_word   = 1'b1;
        next_clocks = `DTD_CNT_EA_LOAD;
      end
      `DTD_OPC_FAR_DATA: begin
        next_class[`DTD_CLS_FAR_DATA] = 1'b1;
        next_mem     = is_mem;
        next_word    = 1'b1;
        next_seg     = 1'b1;
        // Register operand is flagged but still costed, so timing stays defined
        next_illegal = !is_mem;
        next_clocks  = narrow_bus ? `DTD_CNT_FAR_NB : `DTD_CNT_FAR_WB;
      end
      `DTD_OPC_FAR_EXTRA: begin
        next_class[`DTD_CLS_FAR_EXTRA] = 1'b1;
        next_mem     = is_mem;
        next_word    = 1'b1;
        next_seg     = 1'b1;
        next_illegal = !is_mem;
        next_clocks  = narrow_bus ? `DTD_CNT_FAR_NB : `DTD_CNT_FAR_WB;
      end
      `DTD_OPC_FLAGS_TO_ACC: begin
        next_class[`DTD_CLS_FLAGS_TO_ACC] = 1'b1;
        next_acc_high = 1'b1;
        next_clocks   = `DTD_CNT_FLAGS_TO_ACC;
      end
      `DTD_OPC_ACC_TO_FLAGS: begin
        next_class[`DTD_CLS_ACC_TO_FLAGS] = 1'b1;
        next_flags  = 1'b1;
        next_clocks = `DTD_CNT_ACC_TO_FLAGS;
      end

      default: begin
        if (hit_mov_to_rm) begin
          next_class[`DTD_CLS_MOV_TO_RM] = 1'b1;
          next_mem    = is_mem;
          next_word   = w_bit;
          next_clocks = is_mem ? `DTD_CNT_MOV_TO_RM_MEM : `DTD_CNT_REG_MOVE;
        end else if (hit_mov_to_reg) begin
          next_class[`DTD_CLS_MOV_TO_REG] = 1'b1;
          next_mem    = is_mem;
          next_word   = w_bit;
          next_clocks = is_mem ? `DTD_CNT_MOV_TO_REG_MEM : `DTD_CNT_REG_MOVE;
        end else begin
          next_known = 1'b0;
        end

        // Only these marked forms carry byte figures on the narrow bus; the
        // sum is one bit wider than the count and trimmed on purpose
        pen_sum = {1'b0, next_clocks} + {1'b0, `DTD_CNT_WORD_PENALTY};
        if (narrow_bus && next_mem && next_word)
          next_clocks = pen_sum[`DTD_CNT_W-1:0];
      end
    endcase
  end

  // Strobe kept apart: it drops after a gap in requests,
  // while the fields below keep their value
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dec_valid <= 1'b0;
    end else if (clk_en) begin
      dec_valid <= op_valid;
    end
  end

  // Result fields hold between strobes so the consumer may read late
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dec_known    <= 1'b0;
      dec_class    <= `DTD_CLS_NONE;
      dec_clocks   <= `DTD_CNT_NONE;
      mem_operand  <= 1'b0;
      word_operand <= 1'b0;
      illegal_form <= 1'b0;
      reg_field    <= `DTD_REG_NONE;
    end else if (take) begin
      dec_known    <= next_known;
      dec_class    <= next_class;
      dec_clocks   <= next_clocks;
      mem_operand  <= next_mem;
      word_operand <= next_word;
      illegal_form <= next_illegal;
      reg_field    <= op_byte1[`DTD_REG_HI:`DTD_REG_LO];
    end
  end

  // Register file write enables, same hold rule as the fields
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      writes_acc_low  <= 1'b0;
      writes_acc_high <= 1'b0;
      writes_flags    <= 1'b0;
      writes_seg      <= 1'b0;
    end else if (take) begin
      writes_acc_low  <= next_acc_low;
      writes_acc_high <= next_acc_high;
      writes_flags    <= next_flags;
      writes_seg      <= next_seg;
    end
  end

endmodule // dtd_decode

// [hw/dtd_map.vh]
`ifndef DTD_MAP_VH
`define DTD_MAP_VH

// First-byte opcodes
`define DTD_OPC_SEG_LOAD      8'h8e
`define DTD_OPC_SEG_STORE     8'h8c
`define DTD_OPC_TABLE_XLT     8'hd7
`define DTD_OPC_EA_LOAD       8'h8d
`define DTD_OPC_FAR_DATA      8'hc5
`define DTD_OPC_FAR_EXTRA     8'hc4
`define DTD_OPC_FLAGS_TO_ACC  8'h9f
`define DTD_OPC_ACC_TO_FLAGS  8'h9e
// Upper seven bits of the width-bit move forms
`define DTD_OPC_MOV_TO_RM     7'h44
`define DTD_OPC_MOV_TO_REG    7'h45
`define DTD_OPC_HI            7
`define DTD_OPC_TOP_LO        1

// Second-byte fields, plus the width bit of the first byte
`define DTD_MOD_HI            7
`define DTD_MOD_LO            6
`define DTD_MOD_REG           2'h3
`define DTD_REG_HI            5
`define DTD_REG_LO            3
`define DTD_WIDTH_BIT         0
`define DTD_REG_NONE          3'h0

// Class vector, one bit per recognised form
`define DTD_CLS_W             10
`define DTD_CLS_SEG_LOAD      0
`define DTD_CLS_SEG_STORE     1
`define DTD_CLS_TABLE_XLT     2
`define DTD_CLS_EA_LOAD       3
`define DTD_CLS_FAR_DATA      4
`define DTD_CLS_FAR_EXTRA     5
`define DTD_CLS_FLAGS_TO_ACC  6
`define DTD_CLS_ACC_TO_FLAGS  7
`define DTD_CLS_MOV_TO_RM     8
`define DTD_CLS_MOV_TO_REG    9
`define DTD_CLS_NONE          10'h000

// Clock counts
`define DTD_CNT_W             6
`define DTD_CNT_NONE          6'h00
`define DTD_CNT_REG_MOVE      6'h02
`define DTD_CNT_SEG_LOAD_WB   6'h09
`define DTD_CNT_SEG_LOAD_NB   6'h0d
`define DTD_CNT_SEG_STORE_WB  6'h0b
`define DTD_CNT_SEG_STORE_NB  6'h0f
`define DTD_CNT_XLT_WB        6'h0b
`define DTD_CNT_XLT_NB        6'h0f
`define DTD_CNT_EA_LOAD       6'h06
`define DTD_CNT_FAR_WB        6'h12
`define DTD_CNT_FAR_NB        6'h1a
`define DTD_CNT_FLAGS_TO_ACC  6'h02
`define DTD_CNT_ACC_TO_FLAGS  6'h03
`define DTD_CNT_MOV_TO_RM_MEM 6'h0c
`define DTD_CNT_MOV_TO_REG_MEM 6'h09
`define DTD_CNT_WORD_PENALTY  6'h04

`endif

// [testbench/dtd_decode_props.sv]
`include "dtd_map.vh"
module dtd_decode_props (
  input logic                  sys_clk,    // Clock
  input logic                  rstn,       // Reset, active low
  input logic                  clk_en,     // Enable
  input logic                  op_valid,   // Request
  input logic [7:0]            op_byte0,   // Opcode
  input logic [7:0]            op_byte1,   // Mode byte
  input logic                  dec_valid,  // Strobe
  input logic [`DTD_CLS_W-1:0] dec_class,  // Form
  input logic [`DTD_CNT_W-1:0] dec_clocks, // Count
  input logic                  narrow_bus  // Bus width
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire take = clk_en && op_valid;
  wire memf = op_byte1[7:6] != 2'h3;
  valid_follow_a: assert property (take |=> dec_valid)
    else $error("no strobe");
  valid_drop_a: assert property (clk_en && !op_valid |=> !dec_valid)
    else $error("stray strobe");
  clk_freeze_a: assert property (!clk_en |=> $stable(dec_valid) && $stable(dec_clocks))
    else $error("moved while frozen");
  field_hold_a: assert property (!take |=> $stable(dec_class))
    else $error("class not held");
  seg_load_a: assert property (take && op_byte0 == 8'h8e && memf |=>
    dec_clocks == ($past(narrow_bus) ? 6'h0d : 6'h09)) else $error("seg load count");
  xlt_count_a: assert property (take && op_byte0 == 8'hd7 |=>
    dec_clocks == ($past(narrow_bus) ? 6'h0f : 6'h0b)) else $error("translate count");
  far_ptr_a: assert property (take && op_byte0[7:1] == 7'h62 |=>
    dec_clocks == ($past(narrow_bus) ? 6'h1a : 6'h12)) else $error("far count");
  flag_load_a: assert property (take && op_byte0 == 8'h9e |=> dec_clocks == 6'h03)
    else $error("flag count");
  word_pen_a: assert property (take && op_byte0 == 8'h8b && memf |=>
    dec_clocks == ($past(narrow_bus) ? 6'h0d : 6'h09)) else $error("word penalty");
endmodule // dtd_decode_props
bind dtd_decode dtd_decode_props u_props (
  .sys_clk    (sys_clk),
  .rstn       (rstn),
  .clk_en     (clk_en),
  .op_valid   (op_valid),
  .op_byte0   (op_byte0),
  .op_byte1   (op_byte1),
  .dec_valid  (dec_valid),
  .dec_class  (dec_class),
  .dec_clocks (dec_clocks),
  .narrow_bus (narrow_bus)
);

// [testbench/dtd_prefetch_model.sv]
module dtd_prefetch_model (
  input  logic       sys_clk,  // Processor clock
  output logic       op_valid, // Queue head holds an instruction
  output logic [7:0] op_byte0, // First byte at head
  output logic [7:0] op_byte1  // Second byte at head
);
  timeunit 1ns;
  timeprecision 1ps;
  initial op_valid = 1'b0;
  initial op_byte0 = 8'h00;
  initial op_byte1 = 8'h00;
  // Entered on a rising edge; keep chains the next instruction with no gap
  task automatic push(input logic [7:0] b0, input logic [7:0] b1, input logic keep);
    op_valid <= 1'b1;
    op_byte0 <= b0;
    op_byte1 <= b1;
    @(posedge sys_clk);
    if (!keep) begin
      op_valid <= 1'b0;
      // Empty queue shows inverted bytes so stale ones cannot be relied on
      op_byte0 <= ~b0;
      op_byte1 <= ~b1;
    end
  endtask
endmodule // dtd_prefetch_model

// [testbench/test_dtd_decode.sv]
`include "dtd_map.vh"
module test_dtd_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, narrow_bus_pin = 1'b0, op_valid;
  logic dec_valid, dec_known, mem_operand, word_operand, illegal_form, narrow_bus;
  logic writes_acc_low, writes_acc_high, writes_flags, writes_seg;
  logic [2:0] reg_field;
  logic [7:0] op_byte0, op_byte1;
  logic [`DTD_CLS_W-1:0] dec_class;
  logic [`DTD_CNT_W-1:0] dec_clocks;
  int n_mismatch = 0, n_tests = 0;
  // Opcode, mode byte, wide, narrow, class index (f none), word illegal mem al ah flags seg
  logic [38:0] tab [15] = '{
    {8'h8e,8'hc0,6'h02,6'h02,4'h0,7'h41}, {8'h8e,8'h06,6'h09,6'h0d,4'h0,7'h51},
    {8'h8c,8'hd8,6'h02,6'h02,4'h1,7'h40}, {8'h8c,8'h47,6'h0b,6'h0f,4'h1,7'h50},
    {8'hd7,8'h00,6'h0b,6'h0f,4'h2,7'h18}, {8'h8d,8'h86,6'h06,6'h06,4'h3,7'h40},
    {8'hc5,8'h12,6'h12,6'h1a,4'h4,7'h51}, {8'hc4,8'hf0,6'h12,6'h1a,4'h5,7'h61},
    {8'h9f,8'h00,6'h02,6'h02,4'h6,7'h04}, {8'h9e,8'h00,6'h03,6'h03,4'h7,7'h02},
    {8'h8b,8'h07,6'h09,6'h0d,4'h9,7'h50}, {8'h8a,8'h07,6'h09,6'h09,4'h9,7'h10},
    {8'h89,8'h3e,6'h0c,6'h10,4'h8,7'h50}, {8'h88,8'hc1,6'h02,6'h02,4'h8,7'h00},
    {8'h00,8'h00,6'h00,6'h00,4'hf,7'h00}};
  dtd_decode dut (.*);
  dtd_prefetch_model pq (.*);
  always #4 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check({dec_valid, dec_known, dec_clocks, mem_operand, word_operand, illegal_form,
           narrow_bus, reg_field}, 16'h0000);
    check({dec_class, writes_acc_low, writes_acc_high, writes_flags, writes_seg}, 16'h0000);
    @(posedge sys_clk);
    rstn <= 1'b1;
    $display("reset test done");
  endtask
  task automatic t_table(input logic nb);
    logic [38:0] e;
    narrow_bus_pin <= nb;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 15; i++) begin
      e = tab[i];
      pq.push(e[38:31], e[30:23], 1'b0);
      @(negedge sys_clk);
      check({dec_known, dec_clocks}, {e[10:7] != 4'hf, nb ? e[16:11] : e[22:17]});
      check(dec_class, e[10:7] == 4'hf ? 10'h000 : 10'h001 << e[10:7]);
      check({narrow_bus, reg_field}, {nb, e[28:26]});
      check({word_operand, illegal_form, mem_operand, writes_acc_low, writes_acc_high,
             writes_flags, writes_seg}, e[6:0]);
      @(posedge sys_clk);
    end
    $display("table test done, narrow %0d", nb);
  endtask
  task automatic t_stream();
    pq.push(8'hd7, 8'h00, 1'b1);
    pq.push(8'hc5, 8'h00, 1'b1);
    pq.push(8'h9e, 8'h00, 1'b0);
    clk_en <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({dec_valid, dec_clocks}, {1'b1, 6'h03});
    @(posedge sys_clk);
    clk_en <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({dec_valid, dec_class}, {1'b0, 10'h080});
    $display("stream test done");
  endtask
  initial begin
    t_reset();
    t_table(1'b0);
    t_table(1'b1);
    t_stream();
    conclude();
  end
endmodule // test_dtd_decode
